/* File: include/rre_pkg.sv */
// Package for the return and rotate execution block.
// Assumes one core clock domain and opcodes decoded upstream.
package rre_pkg;

    // ==========================================================
    // Operation codes
    typedef enum logic [2:0] {
        RRE_OP_NONE      = 3'b000,
        RRE_OP_IRQ_RET   = 3'b001,
        RRE_OP_SUB_RET   = 3'b010,
        RRE_OP_LIT_RET   = 3'b011,
        RRE_OP_ROT_LEFT  = 3'b100,
        RRE_OP_ROT_RIGHT = 3'b101,
        RRE_OP_LIT_MINUS = 3'b110
    } rre_op_t;

    // ==========================================================
    // Execution states
    typedef enum logic [0:0] {
        RRE_ST_IDLE = 1'b0,
        RRE_ST_POP  = 1'b1
    } rre_state_t;

    // ==========================================================
    // Widths, positions and reset values
    localparam int          RRE_PC_W        = 13;
    localparam int          RRE_DATA_W      = 8;
    localparam int          RRE_ADDR_W      = 7;
    localparam int          RRE_MSB         = 7;
    localparam int          RRE_LSB         = 0;
    localparam int          RRE_NIB_MSB     = 3;
    localparam int          RRE_IRQ_EN_BIT  = 7;
    localparam logic        RRE_DEST_ACC    = 1'b0;
    localparam logic [7:0]  RRE_BYTE_ZERO   = 8'h00;
    localparam logic [12:0] RRE_PC_ZERO     = 13'h0000;
    localparam logic [6:0]  RRE_ADDR_ZERO   = 7'h00;

    // ==========================================================
    // Decoded instruction carrier
    typedef struct packed {
        rre_op_t    op;
        logic [7:0] literal;
        logic [6:0] addr;
        logic       dest;
    } rre_instr_t;

    // ==========================================================
    // Status flags carrier
    typedef struct packed {
        logic zero;
        logic nibble_flag;
        logic carry;
    } rre_flags_t;

endpackage

/* File: src/rre_exec.sv */
// Execution unit for return, rotate and literal-minus-accumulator instructions.
// Assumes issue only when busy_out is low and register data valid with the opcode.
//
// Behaviour
// - An interrupt return pops the return stack and loads its top into the program counter.
// - An interrupt return also sets the global interrupt enable, bit 7 of the interrupt control register.
// - An interrupt return is one word and takes two instruction cycles.
// - A subroutine return pops the stack into the program counter and leaves the interrupt enable alone.
// - A subroutine return takes two instruction cycles.
// - A literal return loads its 8-bit literal into the accumulator.
// - A literal return also pops the stack into the program counter in one word and two cycles.
// - A literal return finishes its pop and program counter reload in exactly two cycles.
// - Rotate left moves the old carry into bit 0 and the old bit 7 into the carry.
// - Rotate left sends its result to the accumulator when the destination bit is 0, else to the register.
// - Rotate right moves the old carry into bit 7 and the old bit 0 into the carry.
// - Rotate right sends its result to the accumulator when the destination bit is 0, else to the register.
`timescale 1ns/1ns
`default_nettype none

module rre_exec (
    input  wire logic                core_clk_in,
    input  wire logic                rst_in,
    input  wire logic                issue_in,
    input  wire rre_pkg::rre_instr_t instr_in,
    input  wire logic [7:0]          reg_data_in,
    input  wire logic [12:0]         stack_top_in,
    output logic                     busy_out,
    output logic                     stack_pop_out,
    output logic                     pc_load_out,
    output logic [12:0]              pc_out,
    output logic                     acc_we_out,
    output logic [7:0]               acc_out,
    output logic                     reg_we_out,
    output logic [6:0]               reg_addr_out,
    output logic [7:0]               reg_data_out,
    output logic                     irq_en_set_out,
    output rre_pkg::rre_flags_t      flags_out
);

    // ==========================================================
    // Functions
    function automatic logic [8:0] rot_left(input logic [7:0] v, input logic c);
        rot_left = {v, c};
    endfunction

    function automatic logic [8:0] rot_right(input logic [7:0] v, input logic c);
        rot_right = {v[rre_pkg::RRE_LSB], c, v[rre_pkg::RRE_MSB:1]};
    endfunction

    // ==========================================================
    // Decode of the current issue
    logic                 go;
    logic                 is_ret;
    logic [8:0]           rot_res;
    rre_pkg::rre_state_t  state_ff;
    rre_pkg::rre_op_t     pend_op_ff;
    logic [12:0]          pend_top_ff;

    assign go     = issue_in && (state_ff == rre_pkg::RRE_ST_IDLE);
    assign is_ret = (instr_in.op == rre_pkg::RRE_OP_IRQ_RET) || (instr_in.op == rre_pkg::RRE_OP_SUB_RET)
                    || (instr_in.op == rre_pkg::RRE_OP_LIT_RET);
    assign rot_res = (instr_in.op == rre_pkg::RRE_OP_ROT_LEFT) ? rot_left(reg_data_in, flags_out.carry)
                                                               : rot_right(reg_data_in, flags_out.carry);

    // ==========================================================
    // Two-cycle return sequencer
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_ff    <= rre_pkg::RRE_ST_IDLE;
            pend_op_ff  <= rre_pkg::RRE_OP_NONE;
            pend_top_ff <= rre_pkg::RRE_PC_ZERO;
        end else begin
            case (state_ff)
                rre_pkg::RRE_ST_IDLE: begin
                    if (go && is_ret) begin
                        state_ff    <= rre_pkg::RRE_ST_POP;
                        pend_op_ff  <= instr_in.op;
                        pend_top_ff <= stack_top_in;
                    end
                end
                rre_pkg::RRE_ST_POP: begin
                    state_ff   <= rre_pkg::RRE_ST_IDLE;
                    pend_op_ff <= rre_pkg::RRE_OP_NONE;
                end
                default: state_ff <= rre_pkg::RRE_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= go && is_ret;
        end
    end

    // ==========================================================
    // Stack pop, program counter and interrupt enable
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            stack_pop_out  <= 1'b0;
            pc_load_out    <= 1'b0;
            pc_out         <= rre_pkg::RRE_PC_ZERO;
            irq_en_set_out <= 1'b0;
        end else begin
            stack_pop_out  <= go && is_ret;
            pc_load_out    <= state_ff == rre_pkg::RRE_ST_POP;
            irq_en_set_out <= (state_ff == rre_pkg::RRE_ST_POP) && (pend_op_ff == rre_pkg::RRE_OP_IRQ_RET);
            if (state_ff == rre_pkg::RRE_ST_POP) begin
                pc_out <= pend_top_ff;
            end
        end
    end

    // ==========================================================
    // Accumulator and register file writes
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            acc_we_out   <= 1'b0;
            acc_out      <= rre_pkg::RRE_BYTE_ZERO;
            reg_we_out   <= 1'b0;
            reg_addr_out <= rre_pkg::RRE_ADDR_ZERO;
            reg_data_out <= rre_pkg::RRE_BYTE_ZERO;
        end else begin
            acc_we_out <= 1'b0;
            reg_we_out <= 1'b0;
            if (go) begin
                case (instr_in.op)
                    rre_pkg::RRE_OP_LIT_RET: begin
                        acc_we_out <= 1'b1;
                        acc_out    <= instr_in.literal;
                    end
                    rre_pkg::RRE_OP_ROT_LEFT, rre_pkg::RRE_OP_ROT_RIGHT: begin
                        if (instr_in.dest == rre_pkg::RRE_DEST_ACC) begin
                            acc_we_out <= 1'b1;
                            acc_out    <= rot_res[rre_pkg::RRE_MSB:0];
                        end else begin
                            reg_we_out   <= 1'b1;
                            reg_addr_out <= instr_in.addr;
                            reg_data_out <= rot_res[rre_pkg::RRE_MSB:0];
                        end
                    end
                    default: begin
                        acc_we_out <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Status flags
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            flags_out <= '0;
        end else if (go) begin
            case (instr_in.op)
                rre_pkg::RRE_OP_ROT_LEFT, rre_pkg::RRE_OP_ROT_RIGHT: begin
                    flags_out.carry <= rot_res[8];
                end
                rre_pkg::RRE_OP_LIT_MINUS: begin
                    flags_out.carry       <= !(reg_data_in > instr_in.literal);
                    flags_out.nibble_flag <= !(reg_data_in[rre_pkg::RRE_NIB_MSB:0]
                                               > instr_in.literal[rre_pkg::RRE_NIB_MSB:0]);
                    flags_out.zero        <= reg_data_in == instr_in.literal;
                end
                default: begin
                    flags_out <= flags_out;
                end
            endcase
        end
    end

    // ==========================================================
    // Checks
    a_ret_pc_two: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (go && is_ret) |-> ##1 (stack_pop_out && !pc_load_out) ##1 (pc_load_out && pc_out == $past(stack_top_in, 2)))
        else $error("return did not reload pc in two cycles");
    a_irq_en_set: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (go && instr_in.op == rre_pkg::RRE_OP_IRQ_RET) |-> ##2 irq_en_set_out)
        else $error("interrupt return did not set enable");
    a_irq_busy: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (go && instr_in.op == rre_pkg::RRE_OP_IRQ_RET) |-> ##1 busy_out ##1 !busy_out)
        else $error("interrupt return not two cycles");
    a_sub_no_gie: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (go && instr_in.op == rre_pkg::RRE_OP_SUB_RET) |-> ##2 (!irq_en_set_out && pc_load_out))
        else $error("subroutine return touched enable");
    a_sub_len: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (go && instr_in.op == rre_pkg::RRE_OP_SUB_RET) |-> ##1 busy_out ##1 !busy_out)
        else $error("subroutine return not two cycles");
    a_lit_acc: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (go && instr_in.op == rre_pkg::RRE_OP_LIT_RET) |-> ##1 (acc_we_out && acc_out == $past(instr_in.literal)))
        else $error("literal not loaded");
    a_lit_pop: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (go && instr_in.op == rre_pkg::RRE_OP_LIT_RET) |-> ##1 stack_pop_out ##1 pc_load_out)
        else $error("literal return did not pop");
    a_lit_exact: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (go && instr_in.op == rre_pkg::RRE_OP_LIT_RET) |-> ##3 !pc_load_out)
        else $error("literal return too long");
    a_rotl_value: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (go && instr_in.op == rre_pkg::RRE_OP_ROT_LEFT && instr_in.dest == rre_pkg::RRE_DEST_ACC) |-> ##1
        (acc_out == {$past(reg_data_in[6:0]), $past(flags_out.carry)} && flags_out.carry == $past(reg_data_in[7])))
        else $error("rotate left wrong");
    a_rotl_dest: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (go && instr_in.op == rre_pkg::RRE_OP_ROT_LEFT) |-> ##1 (acc_we_out != reg_we_out))
        else $error("rotate left destination wrong");
    a_rotr_value: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (go && instr_in.op == rre_pkg::RRE_OP_ROT_RIGHT && instr_in.dest != rre_pkg::RRE_DEST_ACC) |-> ##1
        (reg_we_out && reg_data_out == {$past(flags_out.carry), $past(reg_data_in[7:1])}
         && flags_out.carry == $past(reg_data_in[0])))
        else $error("rotate right wrong");
    a_rotr_dest: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (go && instr_in.op == rre_pkg::RRE_OP_ROT_RIGHT) |-> ##1 (reg_addr_out == $past(instr_in.addr) || acc_we_out))
        else $error("rotate right destination wrong");
    a_rot_flags: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (go && (instr_in.op == rre_pkg::RRE_OP_ROT_LEFT || instr_in.op == rre_pkg::RRE_OP_ROT_RIGHT)) |-> ##1
        (!busy_out && $stable(flags_out.zero) && $stable(flags_out.nibble_flag)))
        else $error("rotate changed other flags");
    a_sub_carry: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (go && instr_in.op == rre_pkg::RRE_OP_LIT_MINUS) |-> ##1
        (flags_out.carry == ($past(reg_data_in) <= $past(instr_in.literal))))
        else $error("subtract carry wrong");
    a_ret_flags: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (go && is_ret) |-> ##1 $stable(flags_out))
        else $error("return changed flags");

endmodule

`default_nettype wire

/* File: verification/test_rre_exec.sv */
// Self-checking testbench for the return and rotate execution block.
// Assumes the block's package is compiled first and the bench alone drives every input.
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin failures++; \
    $display("wrong value at %0t ns: %s", $time, m); end end

module test_rre_exec;
    // ==========================================================
    // Signals
    logic                core_clk_in  = 1'b0;
    logic                rst_in       = 1'b1;
    logic                issue_in     = 1'b0;
    rre_pkg::rre_instr_t instr_in     = '0;
    logic [7:0]          reg_data_in  = 8'h00;
    logic [12:0]         stack_top_in = 13'h0000;
    logic                busy_out;
    logic                stack_pop_out;
    logic                pc_load_out;
    logic [12:0]         pc_out;
    logic                acc_we_out;
    logic [7:0]          acc_out;
    logic                reg_we_out;
    logic [6:0]          reg_addr_out;
    logic [7:0]          reg_data_out;
    logic                irq_en_set_out;
    rre_pkg::rre_flags_t flags_out;
    rre_pkg::rre_flags_t prev;
    int                  failures     = 0;
    int                  cmp_count    = 0;

    always #25 core_clk_in = ~core_clk_in;

    rre_exec u_rre_exec (
        .core_clk_in   (core_clk_in),
        .rst_in        (rst_in),
        .issue_in      (issue_in),
        .instr_in      (instr_in),
        .reg_data_in   (reg_data_in),
        .stack_top_in  (stack_top_in),
        .busy_out      (busy_out),
        .stack_pop_out (stack_pop_out),
        .pc_load_out   (pc_load_out),
        .pc_out        (pc_out),
        .acc_we_out    (acc_we_out),
        .acc_out       (acc_out),
        .reg_we_out    (reg_we_out),
        .reg_addr_out  (reg_addr_out),
        .reg_data_out  (reg_data_out),
        .irq_en_set_out(irq_en_set_out),
        .flags_out     (flags_out)
    );

    // ==========================================================
    // Tasks
    task automatic results();
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Presents one instruction and returns just after the edge that takes it, with issue_in still high.
    task automatic issue(input rre_pkg::rre_op_t op, input logic [7:0] lit, input logic [6:0] addr,
                         input logic dest, input logic [7:0] data, input logic [12:0] top);
        @(posedge core_clk_in);
        issue_in     <= 1'b1;
        instr_in     <= '{op: op, literal: lit, addr: addr, dest: dest};
        reg_data_in  <= data;
        stack_top_in <= top;
        @(posedge core_clk_in);
        prev = flags_out;
    endtask

    task automatic rotate(input rre_pkg::rre_op_t op, input logic dest, input logic [6:0] addr,
                          input logic [7:0] data, input logic [7:0] res, input logic c);
        issue(op, 8'h00, addr, dest, data, 13'h0000);
        issue_in <= 1'b0;
        #1;
        `CHK(acc_we_out, ~dest, "accumulator write strobe")
        `CHK(reg_we_out, dest, "register write strobe")
        `CHK(dest ? reg_data_out : acc_out, res, "rotate result")
        `CHK(dest ? reg_addr_out : addr, addr, "register address")
        `CHK(flags_out.carry, c, "rotate carry")
        `CHK({flags_out.zero, flags_out.nibble_flag}, {prev.zero, prev.nibble_flag}, "other flags")
        `CHK({busy_out, stack_pop_out}, 2'b00, "rotate busy")
    endtask

    task automatic minus(input logic [7:0] lit, input logic [7:0] acc, input rre_pkg::rre_flags_t f);
        issue(rre_pkg::RRE_OP_LIT_MINUS, lit, 7'h00, 1'b0, acc, 13'h0000);
        issue_in <= 1'b0;
        #1;
        `CHK(flags_out, f, "literal minus flags")
    endtask

    // A rotate issued while busy must be dropped.
    task automatic ret(input rre_pkg::rre_op_t op, input logic [7:0] lit, input logic [12:0] top);
        logic is_lit;
        is_lit = (op == rre_pkg::RRE_OP_LIT_RET);
        issue(op, lit, 7'h00, 1'b0, 8'h00, top);
        instr_in <= '{op: rre_pkg::RRE_OP_ROT_LEFT, literal: 8'h00, addr: 7'h05, dest: 1'b1};
        #1;
        `CHK({stack_pop_out, busy_out, pc_load_out}, 3'b110, "pop cycle")
        `CHK(acc_we_out, is_lit, "literal write strobe")
        if (is_lit) `CHK(acc_out, lit, "literal value")
        @(posedge core_clk_in);
        issue_in <= 1'b0;
        #1;
        `CHK({pc_load_out, busy_out, stack_pop_out, reg_we_out}, 4'b1000, "reload cycle")
        `CHK(pc_out, top, "program counter")
        `CHK(irq_en_set_out, op == rre_pkg::RRE_OP_IRQ_RET, "interrupt enable")
        @(posedge core_clk_in);
        #1;
        `CHK({pc_load_out, acc_we_out, reg_we_out, irq_en_set_out}, 4'h0, "after return")
        `CHK(flags_out, prev, "flags kept")
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge core_clk_in);
        rst_in <= 1'b0;
        #1;
        `CHK({busy_out, stack_pop_out, pc_load_out, acc_we_out, reg_we_out}, 5'h00, "reset strobes")
        `CHK(flags_out, 3'b000, "reset flags")
        rotate(rre_pkg::RRE_OP_ROT_LEFT, 1'b0, 7'h12, 8'hE6, 8'hCC, 1'b1);
        rotate(rre_pkg::RRE_OP_ROT_RIGHT, 1'b1, 7'h7F, 8'h01, 8'h80, 1'b1);
        rotate(rre_pkg::RRE_OP_ROT_RIGHT, 1'b0, 7'h00, 8'h02, 8'h81, 1'b0);
        rotate(rre_pkg::RRE_OP_ROT_LEFT, 1'b1, 7'h00, 8'h80, 8'h00, 1'b1);
        minus(8'h10, 8'h11, 3'b000);
        minus(8'h35, 8'h35, 3'b111);
        minus(8'h2F, 8'h13, 3'b011);
        ret(rre_pkg::RRE_OP_IRQ_RET, 8'h00, 13'h1ABC);
        ret(rre_pkg::RRE_OP_SUB_RET, 8'h00, 13'h0155);
        ret(rre_pkg::RRE_OP_LIT_RET, 8'hFF, 13'h1FFF);
        ret(rre_pkg::RRE_OP_LIT_RET, 8'h00, 13'h0000);
        results();
    end

    initial begin
        repeat (2000) @(posedge core_clk_in);
        failures++;
        results();
    end
endmodule

`default_nettype wire
